/* File: hdl/pss_pkg.sv */
package pss_pkg;

   // ***********************************************************
   // Register offsets (byte addresses on APB)
   // ***********************************************************
   localparam logic [7:0] PSS_SLOT_CTRL_OFS  = 8'h00; // Slot choice, startup
   localparam logic [7:0] PSS_SLOT_CMD_OFS   = 8'h04; // Restore / store cmds
   localparam logic [7:0] PSS_SEQ_CTRL_OFS   = 8'h08; // Run, edit, features
   localparam logic [7:0] PSS_SEQ_INDEX_OFS  = 8'h0c; // Edit index, length
   localparam logic [7:0] PSS_SEQ_CMD_OFS    = 8'h10; // Restart command
   localparam logic [7:0] PSS_SEQ_STAT_OFS   = 8'h14; // Current index, busy
   localparam logic [7:0] PSS_WORK_FFC_OFS   = 8'h18; // Working flat-field
   localparam logic [7:0] PSS_WORK_GAIN_OFS  = 8'h1c; // Working gain
   localparam logic [7:0] PSS_WORK_SHUT_OFS  = 8'h20; // Working shutter

   // ***********************************************************
   // Field positions
   // ***********************************************************
   localparam int PSS_RESTORE_BIT  = 0;  // Slot restore command
   localparam int PSS_STORE_BIT    = 1;  // Slot store command
   localparam int PSS_STARTUP_LSB  = 4;  // Startup slot field
   localparam int PSS_RUN_BIT      = 0;  // Sequencer run enable
   localparam int PSS_EDIT_BIT     = 1;  // Sequencer edit mode
   localparam int PSS_PICK_LSB     = 4;  // Feature pick field
   localparam int PSS_ON_LSB       = 8;  // Feature enable bits
   localparam int PSS_LEN_LSB      = 8;  // Sequence length field
   localparam int PSS_RESTART_BIT  = 0;  // Restart command

   // ***********************************************************
   // Reset values and edit-mode defaults
   // ***********************************************************
   localparam logic [5:0]  PSS_LEN_RST     = 6'h01;
   localparam logic [3:0]  PSS_FFC_DEF     = 4'h0;
   localparam logic [7:0]  PSS_GAIN_DEF    = 8'h01;
   localparam logic [23:0] PSS_SHUT_DEF    = 24'd10000;
   localparam int          PSS_SET_W       = 36;  // ffc 4, gain 8, shut 24
   localparam int          PSS_NUM_SETS    = 32;

   // ***********************************************************
   // Enumerations
   // ***********************************************************
   typedef enum logic [1:0] {
      PSS_SLOT_FACTORY,
      PSS_SLOT_ONE,
      PSS_SLOT_TWO
   } pss_slot_type;

   typedef enum logic [1:0] {
      PSS_FEAT_FFC,
      PSS_FEAT_GAIN,
      PSS_FEAT_SHUT
   } pss_feat_type;

endpackage

/* File: hdl/pss_mem.sv */
`timescale 1ns/1ps
// Single-port RAM, registered read data
module pss_mem #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 128
) (
   input  wire logic                     core_clk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   output logic      [WIDTH-1:0]         rd_data
);
   // Storage array, no reset as in a real RAM
   logic [WIDTH-1:0] mem [DEPTH];

   // Write, and read the old contents into the output register every cycle
   always_ff @(posedge core_clk)
   begin
      if (wr_en)
      begin
         mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
   end
endmodule // pss_mem

/* File: hdl/pss_top.sv */
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module pss_top (
   input  wire logic          core_clk,
   input  wire logic          resetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic      [31:0]   prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic          acq_start,
   input  wire logic          triggered_acq_enable,
   output logic      [4:0]    seq_current_index,
   output logic      [3:0]    ffc_select,
   output logic      [7:0]    gain_value,
   output logic      [23:0]   shutter_duration
);
   import pss_pkg::*;

   // ***********************************************************
   // Memory map: slot s, set i at s*32+i; set 0 also slot base
   // ***********************************************************
   // Working set sits in a register; each slot holds 32 sequencer
   // sets in flash-like RAM. Slot 3 of the same RAM is the live set
   // bank, so one copy loop covers restore and store alike.
   localparam int AW = 7;

   // Sync of acquisition pulse from outside domain
   logic       acq_s1_r;
   logic       acq_s2_r;
   logic       acq_s3_r;
   logic       trig_s1_r;
   logic       trig_s2_r;

   // Software-visible control
   logic [1:0] slot_choice_r;            // Selected slot
   logic [1:0] startup_slot_r;           // Startup slot, read back only; reset restores factory
   logic       seq_run_enable_r;         // Sequencer running
   logic       seq_edit_mode_r;          // Edit mode
   logic [1:0] seq_feature_pick_r;       // Feature selector
   logic [2:0] seq_feature_on_r;         // Per-feature enable
   logic [4:0] seq_edit_index_r;         // Set under edit
   logic [5:0] seq_length_r;             // Sets cycled, 1..32
   logic [4:0] cur_idx_r;                // Active set index

   // Working parameters (volatile)
   logic [3:0]  work_ffc_r;
   logic [7:0]  work_gain_r;
   logic [23:0] work_shut_r;

   // Copy engine between slots and sequencer set bank
   typedef enum logic [2:0] {
      PSS_IDLE,
      PSS_RD,
      PSS_RD_WAIT,
      PSS_WR,
      PSS_APPLY,
      PSS_APPLY_WAIT
   } pss_state_type;
   pss_state_type state_r;
   logic       copy_store_r;             // 1 = bank to slot
   logic [1:0] copy_slot_r;              // Slot being copied
   logic [4:0] copy_idx_r;               // Set being copied

   // Memory ports
   logic                mem_we;
   logic [AW-1:0]       mem_addr;
   logic [PSS_SET_W-1:0] mem_wdata;
   logic [PSS_SET_W-1:0] mem_rdata;

   // APB decode
   logic       apb_acc;
   logic       apb_wr;
   logic       busy;
   logic       acq_pulse;
   logic       seq_step;                 // Acquisition that moves the index
   logic       edit_wr;

   // Address of set idx within a slot (slot 3 is the bank)
   function automatic logic [AW-1:0] set_addr(input logic [1:0] slot,
                                              input logic [4:0] idx);
      set_addr = {slot, idx};
   endfunction

   // Pack working fields into a memory word
   function automatic logic [PSS_SET_W-1:0] pack_set(
      input logic [3:0] f, input logic [7:0] g, input logic [23:0] s);
      pack_set = {f, g, s};
   endfunction

   assign busy      = (state_r != PSS_IDLE);
   assign apb_acc   = psel && penable;
   assign apb_wr    = apb_acc && pwrite && !busy;
   assign acq_pulse = acq_s2_r && !acq_s3_r;
   // Only a counted acquisition applies a set, so an acquisition while
   // stopped or free-running leaves host-written working values alone
   assign seq_step  = acq_pulse && seq_run_enable_r && !seq_edit_mode_r &&
                      trig_s2_r && !busy;
   // Edit-mode write to a working field lands in the edited set
   assign edit_wr   = apb_wr && seq_edit_mode_r &&
                      (paddr == PSS_WORK_FFC_OFS ||
                       paddr == PSS_WORK_GAIN_OFS ||
                       paddr == PSS_WORK_SHUT_OFS);

   // ***********************************************************
   // Input synchronisers
   // ***********************************************************
   // Pins pass two flops before use
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         acq_s1_r  <= 1'b0;
         acq_s2_r  <= 1'b0;
         acq_s3_r  <= 1'b0;
         trig_s1_r <= 1'b0;
         trig_s2_r <= 1'b0;
      end
      else
      begin
         acq_s1_r  <= acq_start;
         acq_s2_r  <= acq_s1_r;
         acq_s3_r  <= acq_s2_r;
         trig_s1_r <= triggered_acq_enable;
         trig_s2_r <= trig_s1_r;
      end
   end

   // ***********************************************************
   // APB control registers
   // ***********************************************************
   // Writes are held off (pready low) while the copy engine runs
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         slot_choice_r      <= 2'(PSS_SLOT_FACTORY);
         startup_slot_r     <= 2'(PSS_SLOT_FACTORY);
         seq_run_enable_r   <= 1'b0;
         seq_edit_mode_r    <= 1'b0;
         seq_feature_pick_r <= 2'(PSS_FEAT_FFC);
         seq_feature_on_r   <= 3'h0;
         seq_edit_index_r   <= 5'h00;
         seq_length_r       <= PSS_LEN_RST;
      end
      else if (apb_wr)
      begin
         unique case (paddr)
            PSS_SLOT_CTRL_OFS:
            begin
               // Only three slot codes exist; others ignored
               if (pwdata[1:0] != 2'h3)
                  slot_choice_r <= pwdata[1:0];
               if (pwdata[PSS_STARTUP_LSB+:2] != 2'h3)
                  startup_slot_r <= pwdata[PSS_STARTUP_LSB+:2];
            end
            PSS_SEQ_CTRL_OFS:
            begin
               seq_run_enable_r   <= pwdata[PSS_RUN_BIT];
               seq_edit_mode_r    <= pwdata[PSS_EDIT_BIT];
               seq_feature_pick_r <= pwdata[PSS_PICK_LSB+:2];
               // Edit entry enables all features by default
               if (pwdata[PSS_EDIT_BIT] && !seq_edit_mode_r)
                  seq_feature_on_r <= 3'h7;
               else if (pwdata[PSS_PICK_LSB+:2] != 2'h3)
                  seq_feature_on_r[pwdata[PSS_PICK_LSB+:2]] <=
                     pwdata[PSS_ON_LSB];
            end
            PSS_SEQ_INDEX_OFS:
            begin
               seq_edit_index_r <= pwdata[4:0];
               // Lengths outside 1..32 are ignored
               if (pwdata[PSS_LEN_LSB+:6] >= 6'd1 &&
                   pwdata[PSS_LEN_LSB+:6] <= 6'(PSS_NUM_SETS))
                  seq_length_r <= pwdata[PSS_LEN_LSB+:6];
            end
            default:
            begin
            end
         endcase
      end
   end

   // ***********************************************************
   // Sequencer index
   // ***********************************************************
   // Advances only when running, not editing, and triggered
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         cur_idx_r <= 5'h00;
      else if (apb_wr && paddr == PSS_SEQ_CMD_OFS && pwdata[PSS_RESTART_BIT])
         cur_idx_r <= 5'h00;
      else if (seq_step)
      begin
         if ({1'b0, cur_idx_r} + 6'd1 >= seq_length_r)
            cur_idx_r <= 5'h00;
         else
            cur_idx_r <= cur_idx_r + 5'd1;
      end
   end

   // ***********************************************************
   // Copy engine and working parameters
   // ***********************************************************
   // Slot 3 of the memory is the live sequencer bank. Restore copies
   // slot s sets 0..31 into the bank; store copies the bank to slot
   // s unless s is the factory slot. Reset starts a restore from the factory slot, so anything
   // not stored is gone
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         state_r      <= PSS_RD;
         copy_store_r <= 1'b0;
         copy_slot_r  <= 2'(PSS_SLOT_FACTORY);
         copy_idx_r   <= 5'h00;
      end
      else
      begin
         unique case (state_r)
            PSS_IDLE:
            begin
               copy_idx_r  <= 5'h00;
               copy_slot_r <= slot_choice_r;
               if (apb_wr && paddr == PSS_SLOT_CMD_OFS)
               begin
                  if (pwdata[PSS_RESTORE_BIT])
                  begin
                     copy_store_r <= 1'b0;
                     state_r      <= PSS_RD;
                  end
                  else if (pwdata[PSS_STORE_BIT] &&
                           slot_choice_r != 2'(PSS_SLOT_FACTORY))
                  begin
                     copy_store_r <= 1'b1;
                     state_r      <= PSS_RD;
                  end
               end
               else if (seq_step)
                  // Edits stay in working; re-applying would lose fields
                  state_r <= PSS_APPLY;
            end
            PSS_RD:
               state_r <= PSS_RD_WAIT;
            PSS_RD_WAIT:
               state_r <= PSS_WR;
            PSS_WR:
            begin
               copy_idx_r <= copy_idx_r + 5'd1;
               state_r    <= (copy_idx_r == 5'd31) ? PSS_APPLY : PSS_RD;
            end
            PSS_APPLY:
               state_r <= PSS_APPLY_WAIT;
            PSS_APPLY_WAIT:
               state_r <= PSS_IDLE;
            default:
               state_r <= PSS_IDLE;
         endcase
      end
   end

   // Memory address and data by engine phase
   always_comb
   begin
      mem_we    = 1'b0;
      mem_addr  = set_addr(2'h3, cur_idx_r);
      mem_wdata = mem_rdata;
      if (state_r == PSS_RD || state_r == PSS_RD_WAIT)
         mem_addr = copy_store_r ? set_addr(2'h3, copy_idx_r)
                                 : set_addr(copy_slot_r, copy_idx_r);
      else if (state_r == PSS_WR)
      begin
         mem_we   = 1'b1;
         mem_addr = copy_store_r ? set_addr(copy_slot_r, copy_idx_r)
                                 : set_addr(2'h3, copy_idx_r);
      end
      else if (state_r == PSS_IDLE && edit_wr)
      begin
         // Edited set takes the new field, others from working
         mem_we    = 1'b1;
         mem_addr  = set_addr(2'h3, seq_edit_index_r);
         mem_wdata = pack_set(
            (paddr == PSS_WORK_FFC_OFS)  ? pwdata[3:0]  : work_ffc_r,
            (paddr == PSS_WORK_GAIN_OFS) ? pwdata[7:0]  : work_gain_r,
            (paddr == PSS_WORK_SHUT_OFS) ? pwdata[23:0] : work_shut_r);
      end
   end

   pss_mem #(
      .WIDTH (PSS_SET_W),
      .DEPTH (1 << AW)
   ) u_mem (
      .core_clk (core_clk),
      .wr_en    (mem_we),
      .addr     (mem_addr),
      .wr_data  (mem_wdata),
      .rd_data  (mem_rdata)
   );

   // Working fields: host writes, edit defaults, set application
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         work_ffc_r  <= PSS_FFC_DEF;
         work_gain_r <= PSS_GAIN_DEF;
         work_shut_r <= PSS_SHUT_DEF;
      end
      else if (apb_wr && paddr == PSS_SEQ_CTRL_OFS &&
               pwdata[PSS_EDIT_BIT] && !seq_edit_mode_r)
      begin
         work_ffc_r  <= PSS_FFC_DEF;
         work_gain_r <= PSS_GAIN_DEF;
         work_shut_r <= PSS_SHUT_DEF;
      end
      else if (apb_wr && paddr == PSS_WORK_FFC_OFS)
         work_ffc_r <= pwdata[3:0];
      else if (apb_wr && paddr == PSS_WORK_GAIN_OFS)
         work_gain_r <= pwdata[7:0];
      else if (apb_wr && paddr == PSS_WORK_SHUT_OFS)
         work_shut_r <= pwdata[23:0];
      else if (state_r == PSS_APPLY_WAIT &&
               (seq_run_enable_r || !copy_store_r))
      begin
         // Each field taken if its feature is on, or always when not running
         if (seq_feature_on_r[PSS_FEAT_FFC] || !seq_run_enable_r)
            work_ffc_r  <= mem_rdata[35:32];
         if (seq_feature_on_r[PSS_FEAT_GAIN] || !seq_run_enable_r)
            work_gain_r <= mem_rdata[31:24];
         if (seq_feature_on_r[PSS_FEAT_SHUT] || !seq_run_enable_r)
            work_shut_r <= mem_rdata[23:0];
      end
   end

   // ***********************************************************
   // APB read and handshake
   // ***********************************************************
   // Read data registered in the setup cycle; unmapped reads zero
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         unique case (paddr)
            PSS_SLOT_CTRL_OFS:
               prdata <= {26'h0, startup_slot_r, 2'h0, slot_choice_r};
            PSS_SEQ_CTRL_OFS:
               prdata <= {21'h0, seq_feature_on_r, 2'h0,
                          seq_feature_pick_r, 2'h0,
                          seq_edit_mode_r, seq_run_enable_r};
            PSS_SEQ_INDEX_OFS:
               prdata <= {18'h0, seq_length_r, 3'h0, seq_edit_index_r};
            PSS_SEQ_STAT_OFS:
               prdata <= {26'h0, busy, cur_idx_r};
            PSS_WORK_FFC_OFS:  prdata <= {28'h0, work_ffc_r};
            PSS_WORK_GAIN_OFS: prdata <= {24'h0, work_gain_r};
            PSS_WORK_SHUT_OFS: prdata <= {8'h0, work_shut_r};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Writes wait while busy; reads never wait
   assign pready  = !(psel && pwrite && busy);
   assign pslverr = 1'b0;

   // Outputs to datapaths
   assign seq_current_index = cur_idx_r;
   assign ffc_select        = work_ffc_r;
   assign gain_value        = work_gain_r;
   assign shutter_duration  = work_shut_r;
endmodule // pss_top

/* File: dv/pss_top_sva.sv */
`timescale 1ns/1ps
// ****************************************************
// Port checker for the parameter set sequencer
// ****************************************************
module pss_top_sva
   import pss_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        acq_start,
   input wire logic        triggered_acq_enable,
   input wire logic [4:0]  seq_current_index,
   input wire logic [3:0]  ffc_select,
   input wire logic [7:0]  gain_value,
   input wire logic [23:0] shutter_duration
);
   logic       wr_done; // Completed APB write
   logic       edit_q;  // Edit bit as last written
   logic [7:0] wgain;   // Gain byte of write data
   assign wr_done = psel && penable && pwrite && pready;
   assign wgain = pwdata[7:0];
   // Shadow the edit bit so only its rising edge counts
   always_ff @(posedge core_clk)
   begin
      if (!resetn)
         edit_q <= 1'b0;
      else if (wr_done && paddr == PSS_SEQ_CTRL_OFS)
         edit_q <= pwdata[PSS_EDIT_BIT];
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // ****************************************************
   // Assertions
   // ****************************************************
   rst_vals_a: assert property (
      $rose(resetn) |-> seq_current_index == 5'h00 &&
      gain_value == PSS_GAIN_DEF && shutter_duration == PSS_SHUT_DEF)
      else $error("Working values not at defaults after reset");
   idx_step_a: assert property (
      $changed(seq_current_index) |-> seq_current_index == 5'h00 ||
      seq_current_index == $past(seq_current_index) + 5'h01)
      else $error("Active index jumped");
   idx_hold_a: assert property (
      (!triggered_acq_enable && !wr_done) [*5] |=>
      $stable(seq_current_index))
      else $error("Index moved in free-running mode");
   restart_a: assert property (
      wr_done && paddr == PSS_SEQ_CMD_OFS && pwdata[PSS_RESTART_BIT]
      |=> seq_current_index == 5'h00)
      else $error("Restart did not clear index");
   read_fast_a: assert property (
      psel && penable && !pwrite |-> pready)
      else $error("Read stalled");
   write_done_a: assert property (
      psel && penable && pwrite |-> ##[0:150] pready)
      else $error("Write never completed");
   gain_wr_a: assert property (
      wr_done && paddr == PSS_WORK_GAIN_OFS |=> gain_value == $past(wgain))
      else $error("Gain write not taken");
   edit_dflt_a: assert property (
      wr_done && paddr == PSS_SEQ_CTRL_OFS && pwdata[PSS_EDIT_BIT] &&
      !edit_q |-> ##[1:3] (gain_value == PSS_GAIN_DEF &&
      shutter_duration == PSS_SHUT_DEF && ffc_select == PSS_FFC_DEF))
      else $error("Edit entry did not load defaults");
   // Main scenarios reached
   cover property (wr_done && paddr == PSS_SEQ_CMD_OFS);
   cover property ($changed(seq_current_index) && seq_current_index == 5'h00);
   cover property (wr_done && paddr == PSS_SLOT_CMD_OFS);
endmodule // pss_top_sva

/* File: dv/parameter_set_sequencer_test.sv */
`timescale 1ns/1ps
// ****************************************************
// Testbench for the parameter set sequencer
// ****************************************************
module parameter_set_sequencer_test;
   import pss_pkg::*;
   logic        core_clk, resetn, psel, penable, pwrite;  // Bus and clock
   logic [7:0]  paddr;                // Byte address
   logic [31:0] pwdata, prdata, rd;   // Bus data, last read
   logic        pready, pslverr;      // Slave answer
   logic        acq_start, triggered_acq_enable; // Trigger side
   logic [4:0]  seq_current_index;    // Active set
   logic [3:0]  ffc_select;           // Working flat-field
   logic [7:0]  gain_value;           // Working gain
   logic [23:0] shutter_duration;     // Working shutter
   int          fail_count = 0;       // Mismatches
   int          n_tests = 0;          // Comparisons
   int          i;                    // Loop index
   pss_top DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .acq_start(acq_start), .triggered_acq_enable(triggered_acq_enable),
      .seq_current_index(seq_current_index), .ffc_select(ffc_select),
      .gain_value(gain_value), .shutter_duration(shutter_duration));
   // 100 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ****************************************************
   // Tasks
   // ****************************************************
   // Verdict and end of run
   task close_out;
      $display("Checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Compare seen against expected
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; writes may stall while the engine is busy
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
      begin
         n++;
         if (n > 200)
         begin
            fail_count++;
            close_out();
         end
         @(posedge core_clk);
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // Read, mask, compare
   task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd & m, e);
   endtask
   // Poll busy with a bound
   task wait_idle;
      int n;
      for (n = 0; n < 300; n++)
      begin
         apb(1'b0, PSS_SEQ_STAT_OFS, 32'h0);
         if (rd[5] === 1'b0)
            break;
      end
      if (n == 300)
      begin
         fail_count++;
         close_out();
      end
   endtask
   // Acquisition pulse, then room for sync and apply
   task acq;
      acq_start <= 1'b1;
      repeat (2) @(posedge core_clk);
      acq_start <= 1'b0;
      repeat (12) @(posedge core_clk);
   endtask
   // Working values of set k as programmed below
   task work_chk(input int k);
      chk(32'(ffc_select), 32'(k + 4));
      chk(32'(gain_value), 32'(k + 2));
      chk(32'(shutter_duration), 32'(1000 * (k + 3)));
   endtask
   // ****************************************************
   // Main sequence
   // ****************************************************
   initial
   begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      acq_start = 1'b0;
      triggered_acq_enable = 1'b0;
      repeat (6) @(posedge core_clk);
      chk(32'(seq_current_index), 32'h0);
      chk(32'(shutter_duration), 32'(PSS_SHUT_DEF));
      resetn <= 1'b1;
      wait_idle();
      rdchk(PSS_SEQ_STAT_OFS, 32'h3f, 32'h0);
      rdchk(8'h3c, 32'hffffffff, 32'h0);
      chk(32'(pslverr), 32'h0);
      $display("Reset test done");
      // Pick features with sequencing off, then edit
      wr(PSS_SEQ_CTRL_OFS, 32'h0);
      for (i = 0; i < 3; i++)
         wr(PSS_SEQ_CTRL_OFS, 32'h100 | (i << 4));
      rdchk(PSS_SEQ_CTRL_OFS, 32'h700, 32'h700);
      wr(PSS_SEQ_CTRL_OFS, 32'h102);
      repeat (3) @(posedge core_clk);
      chk(32'(gain_value), 32'(PSS_GAIN_DEF));
      chk(32'(ffc_select), 32'(PSS_FFC_DEF));
      for (i = 0; i < 4; i++)
      begin
         wr(PSS_SEQ_INDEX_OFS, 32'h400 | i);
         wr(PSS_WORK_FFC_OFS, i + 4);
         wr(PSS_WORK_GAIN_OFS, i + 2);
         wr(PSS_WORK_SHUT_OFS, 1000 * (i + 3));
      end
      rdchk(PSS_SEQ_INDEX_OFS, 32'h3f1f, 32'h0403);
      wr(PSS_SEQ_CTRL_OFS, 32'h101);
      triggered_acq_enable <= 1'b1;
      $display("Configure test done");
      // Step nine times round four sets, wrapping twice
      for (i = 1; i < 10; i++)
      begin
         acq();
         chk(32'(seq_current_index), i % 4);
         work_chk(i % 4);
      end
      // Gain off: it keeps its value, flat-field moves on
      wr(PSS_SEQ_CTRL_OFS, 32'h011);
      acq();
      chk(32'(ffc_select), 32'h6);
      chk(32'(gain_value), 32'h3);
      triggered_acq_enable <= 1'b0;
      repeat (4) @(posedge core_clk);
      acq();
      chk(32'(seq_current_index), 32'h2);
      triggered_acq_enable <= 1'b1;
      wr(PSS_SEQ_CMD_OFS, 32'h1);
      repeat (2) @(posedge core_clk);
      chk(32'(seq_current_index), 32'h0);
      wr(PSS_SEQ_INDEX_OFS, 32'h0);
      rdchk(PSS_SEQ_INDEX_OFS, 32'h3f00, 32'h0400);
      $display("Sequence test done");
      // Slot code 3 refused, store, spoil, restore
      wr(PSS_SLOT_CTRL_OFS, 32'h13);
      rdchk(PSS_SLOT_CTRL_OFS, 32'h33, 32'h10);
      wr(PSS_SLOT_CMD_OFS, 32'h2);
      rdchk(PSS_SEQ_STAT_OFS, 32'h20, 32'h0);
      wr(PSS_SLOT_CTRL_OFS, 32'h11);
      wr(PSS_SLOT_CMD_OFS, 32'h2);
      wait_idle();
      wr(PSS_SEQ_CTRL_OFS, 32'h102);
      wr(PSS_SEQ_INDEX_OFS, 32'h401);
      wr(PSS_WORK_FFC_OFS, 32'hf);
      wr(PSS_SEQ_CTRL_OFS, 32'h101);
      wr(PSS_SLOT_CMD_OFS, 32'h1);
      wait_idle();
      chk(32'(ffc_select), 32'h4);
      acq();
      chk(32'(ffc_select), 32'h5);
      $display("Slot test done");
      close_out();
   end
endmodule // parameter_set_sequencer_test

bind pss_top pss_top_sva CHK (.core_clk(core_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .acq_start(acq_start), .triggered_acq_enable(triggered_acq_enable),
   .seq_current_index(seq_current_index), .ffc_select(ffc_select),
   .gain_value(gain_value), .shutter_duration(shutter_duration));
